// File: verilog/fspc_regs.sv
// Purpose: segment, volatile setup and flag registers of a serial flash
// Assumes: serial bus pins come from outside and are synchronised here
// Notes:   bits are sampled on a rising serial clock, msb first
`include "fspc_cfg.svh"

// Operation
// [R1] segment bit supplies address bit 24
// [R2] program and erase stay in selected segment
// [R3] bulk erase covers the whole array
// [R4] read crosses segment end, wraps at zero
// [R5] read crossing leaves segment bit unchanged
// [R6] segment bit loads from nonvolatile strap
// [R7] four-byte addressing ignores segment bit
// [R8] bit 7 low enables quad protocol
// [R9] bit 6 low enables dual protocol
// [R10] both low gives quad, applied on write
// [R11] bit 4 high enables hold/reset pin
// [R12] bit 3 low enables supply acceleration
// [R13] setup applies at write, all protocols
// [R14] flag bit 7 low while busy
// [R15] reserved bits held and read zero
// [R16] status self clears, errors wait clear
module fspc_regs #(
	parameter int ADDR_W = 25
) (
	input  wire logic                i_clk_sys,
	input  wire logic                i_reset,
	input  wire logic                i_cs_n,
	input  wire logic                i_sclk,
	input  wire logic                i_mosi,
	input  wire logic                i_nv_seg_default,
	input  wire logic                i_addr4_en,
	input  wire logic [ADDR_W-2:0]   i_host_addr,
	input  wire logic                i_bulk_erase,
	input  wire logic                i_read_step,
	input  wire logic                i_busy,
	input  wire logic                i_err_erase,
	input  wire logic                i_err_prog,
	input  wire logic                i_err_vpp,
	input  wire logic                i_err_prot,
	input  wire logic                i_erase_susp,
	input  wire logic                i_prog_susp,
	output logic                     o_miso,
	output logic                     o_miso_oe,
	output logic [ADDR_W-1:0]        o_array_addr,
	output logic                     o_pe_whole_array,
	output logic [1:0]               o_protocol,
	output logic                     o_hold_reset_en,
	output logic                     o_vpp_accel_en,
	output logic [2:0]               o_drive_strength
);
	if (ADDR_W != `FSPC_SEG_ADDR_BIT + 1) begin : g_addr_w_check
		$error("ADDR_W must be one above the segment address bit");
	end

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	logic [2:0] sync1_ff;
	logic [2:0] sync2_ff;
	logic       sclk_d_ff;
	always_ff @(posedge i_clk_sys) begin
		sync1_ff  <= {i_cs_n, i_sclk, i_mosi};
		sync2_ff  <= sync1_ff;
		sclk_d_ff <= sync2_ff[1];
	end
	wire cs_n  = sync2_ff[2];
	wire mosi  = sync2_ff[0];
	wire rise  = sync2_ff[1] & ~sclk_d_ff & ~cs_n;
	wire fall  = ~sync2_ff[1] & sclk_d_ff & ~cs_n;

	// ************************************************************
	// serial command engine
	// ************************************************************
	fspc_pkg::fspc_state_t state_ff;
	logic [7:0] shift_ff;
	logic [2:0] bit_cnt_ff;
	logic [7:0] cmd_ff;
	logic [7:0] seg_ff;
	logic [7:0] evs_ff;
	logic [7:0] flags_ff;
	logic       seg_loaded_ff;
	logic [7:0] tx_ff;
	wire  [7:0] nxt_shift = {shift_ff[6:0], mosi};
	wire  [7:0] rd_word;
	wire        byte_done = rise && bit_cnt_ff == 3'h7;

	function automatic logic [7:0] read_value(input logic [7:0] c, input logic [7:0] s,
		input logic [7:0] e, input logic [7:0] f);
		case (c)
			`FSPC_CMD_RD_SEG:   read_value = s;
			`FSPC_CMD_RD_EVS:   read_value = e;
			`FSPC_CMD_RD_FLAGS: read_value = f;
			default:            read_value = 8'h00;
		endcase
	endfunction

	assign rd_word = read_value(cmd_ff, seg_ff, evs_ff, flags_ff);

	always_ff @(posedge i_clk_sys) begin
		if (i_reset || cs_n) begin
			state_ff   <= fspc_pkg::FSPC_ST_CMD;
			bit_cnt_ff <= 3'h0;
			shift_ff   <= 8'h00;
			cmd_ff     <= 8'h00;
		end else if (rise) begin
			shift_ff   <= nxt_shift;
			bit_cnt_ff <= bit_cnt_ff + 3'h1;
			if (byte_done) begin
				case (state_ff)
					fspc_pkg::FSPC_ST_CMD: begin
						cmd_ff <= nxt_shift;
						case (nxt_shift)
							`FSPC_CMD_WR_SEG, `FSPC_CMD_WR_EVS:
								state_ff <= fspc_pkg::FSPC_ST_WDATA;
							`FSPC_CMD_RD_SEG, `FSPC_CMD_RD_EVS, `FSPC_CMD_RD_FLAGS:
								state_ff <= fspc_pkg::FSPC_ST_RDATA;
							default:
								state_ff <= fspc_pkg::FSPC_ST_IDLE;
						endcase
					end
					fspc_pkg::FSPC_ST_WDATA: state_ff <= fspc_pkg::FSPC_ST_IDLE;
					default:                 state_ff <= state_ff;
				endcase
			end
		end
	end

	// ************************************************************
	// segment register
	// ************************************************************
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			seg_ff        <= 8'h00;
			seg_loaded_ff <= 1'b0;
		end else if (!seg_loaded_ff) begin
			// [R6] strap load after reset
			seg_ff        <= {7'h00, i_nv_seg_default};
			seg_loaded_ff <= 1'b1;
		end else if (byte_done && state_ff == fspc_pkg::FSPC_ST_WDATA
				&& cmd_ff == `FSPC_CMD_WR_SEG) begin
			// [R15] reserved bits forced zero
			seg_ff <= {7'h00, nxt_shift[`FSPC_SEG_BIT]};
		end
	end

	// ************************************************************
	// volatile setup register
	// ************************************************************
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			evs_ff <= `FSPC_EVS_RESET;
		end else if (byte_done && state_ff == fspc_pkg::FSPC_ST_WDATA
				&& cmd_ff == `FSPC_CMD_WR_EVS) begin
			// [R13] write applies at once
			evs_ff <= nxt_shift & ~(8'h01 << `FSPC_EVS_RSV_BIT);
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			o_protocol       <= fspc_pkg::FSPC_PROTO_EXT;
			o_hold_reset_en  <= 1'b1;
			o_vpp_accel_en   <= 1'b0;
			o_drive_strength <= 3'h7;
		end else begin
			// [R10] quad wins over dual
			if (!evs_ff[`FSPC_EVS_QUAD_BIT])
				// [R8] quad enable low
				o_protocol <= fspc_pkg::FSPC_PROTO_QUAD;
			else if (!evs_ff[`FSPC_EVS_DUAL_BIT])
				// [R9] dual enable low
				o_protocol <= fspc_pkg::FSPC_PROTO_DUAL;
			else
				o_protocol <= fspc_pkg::FSPC_PROTO_EXT;
			// [R11] hold/reset enable
			o_hold_reset_en  <= evs_ff[`FSPC_EVS_HOLD_BIT];
			// [R12] acceleration enable low
			o_vpp_accel_en   <= ~evs_ff[`FSPC_EVS_ACC_BIT];
			o_drive_strength <= evs_ff[2:0];
		end
	end

	// ************************************************************
	// flag register
	// ************************************************************
	wire clr_flags = byte_done && state_ff == fspc_pkg::FSPC_ST_CMD
		&& nxt_shift == `FSPC_CMD_CLR_FLAGS;
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			flags_ff <= 8'h80;
		end else begin
			// [R14] ready bit tracks busy
			flags_ff[`FSPC_FLG_READY_BIT] <= ~i_busy;
			// [R16] status bits self clear
			flags_ff[6]                   <= i_erase_susp;
			flags_ff[2]                   <= i_prog_susp;
			flags_ff[`FSPC_FLG_ADDR4_BIT] <= i_addr4_en;
			// [R16] errors sticky, set wins
			flags_ff[`FSPC_FLG_ERASE_ERR] <= i_err_erase | (flags_ff[5] & ~clr_flags);
			flags_ff[`FSPC_FLG_PROG_ERR]  <= i_err_prog  | (flags_ff[4] & ~clr_flags);
			flags_ff[`FSPC_FLG_VPP_ERR]   <= i_err_vpp   | (flags_ff[3] & ~clr_flags);
			flags_ff[`FSPC_FLG_PROT_ERR]  <= i_err_prot  | (flags_ff[1] & ~clr_flags);
		end
	end

	// ************************************************************
	// read data out, changed on falling serial clock
	// ************************************************************
	always_ff @(posedge i_clk_sys) begin
		if (i_reset || cs_n) begin
			tx_ff     <= 8'h00;
			o_miso    <= 1'b0;
			o_miso_oe <= 1'b0;
		end else if (byte_done && state_ff == fspc_pkg::FSPC_ST_CMD) begin
			tx_ff <= read_value(nxt_shift, seg_ff, evs_ff, flags_ff);
		end else if (fall && state_ff == fspc_pkg::FSPC_ST_RDATA) begin
			o_miso_oe <= 1'b1;
			// repeat the register for as long as clocks keep coming
			if (bit_cnt_ff == 3'h0) begin
				o_miso <= rd_word[7];
				tx_ff  <= {rd_word[6:0], 1'b0};
			end else begin
				o_miso <= tx_ff[7];
				tx_ff  <= {tx_ff[6:0], 1'b0};
			end
		end
	end

	// ************************************************************
	// array address forming
	// ************************************************************
	logic [ADDR_W-1:0] rd_addr_ff;
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			rd_addr_ff       <= '0;
			o_array_addr     <= '0;
			o_pe_whole_array <= 1'b0;
		end else begin
			// [R3] bulk erase whole array
			o_pe_whole_array <= i_bulk_erase;
			if (i_read_step) begin
				// [R4] natural wrap to zero, [R5] segment untouched
				rd_addr_ff <= rd_addr_ff + 1'b1;
			end else if (i_addr4_en) begin
				// [R7] segment bit ignored
				rd_addr_ff <= {1'b0, i_host_addr};
			end else begin
				// [R1] [R2] segment bit is address bit 24
				rd_addr_ff <= {seg_ff[`FSPC_SEG_BIT], i_host_addr};
			end
			o_array_addr <= rd_addr_ff;
		end
	end
endmodule

// File: verilog/fspc_cfg.svh
// Purpose: constants of the segment and protocol setup block
// Assumes: eight-bit registers reached by serial commands
// Notes:   command codes, field positions and reset values
`ifndef FSPC_CFG_SVH
`define FSPC_CFG_SVH

// ************************************************************
// command codes
// ************************************************************
`define FSPC_CMD_RD_SEG     8'hC8
`define FSPC_CMD_WR_SEG     8'hC5
`define FSPC_CMD_RD_EVS     8'h65
`define FSPC_CMD_WR_EVS     8'h61
`define FSPC_CMD_RD_FLAGS   8'h70
`define FSPC_CMD_CLR_FLAGS  8'h50
`define FSPC_CMD_WREN       8'h06

// ************************************************************
// fields and reset values
// ************************************************************
`define FSPC_SEG_BIT        0
`define FSPC_EVS_QUAD_BIT   7
`define FSPC_EVS_DUAL_BIT   6
`define FSPC_EVS_RSV_BIT    5
`define FSPC_EVS_HOLD_BIT   4
`define FSPC_EVS_ACC_BIT    3
`define FSPC_EVS_RESET      8'hDF
`define FSPC_FLG_READY_BIT  7
`define FSPC_FLG_ERASE_ERR  5
`define FSPC_FLG_PROG_ERR   4
`define FSPC_FLG_VPP_ERR    3
`define FSPC_FLG_PROT_ERR   1
`define FSPC_FLG_ADDR4_BIT  0
`define FSPC_SEG_ADDR_BIT   24

`endif

// File: verilog/fspc_pkg.sv
// Purpose: types of the segment and protocol setup block
// Assumes: nothing beyond the constants header
// Notes:   serial command states and protocol modes
package fspc_pkg;
	typedef enum logic [1:0] {
		FSPC_ST_CMD,
		FSPC_ST_WDATA,
		FSPC_ST_RDATA,
		FSPC_ST_IDLE
	} fspc_state_t;

	typedef enum logic [1:0] {
		FSPC_PROTO_EXT,
		FSPC_PROTO_DUAL,
		FSPC_PROTO_QUAD
	} fspc_proto_t;
endpackage

// File: dv/fspc_host.sv
// Purpose: serial host driving register commands
// Assumes: clock idles low, data msb first
// Notes:   sclk stands still between frames
module fspc_host (
	input  wire logic i_clk_sys,
	input  wire logic i_miso,
	output logic      o_cs_n,
	output logic      o_sclk,
	output logic      o_mosi
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		o_cs_n = 1'b1;
		o_sclk = 1'b0;
		o_mosi = 1'b0;
	end
	task automatic xfer(input logic [15:0] w, input int n, output logic [7:0] r);
		for (int i = n - 1; i >= 0; i--) begin
			@(posedge i_clk_sys);
			o_cs_n <= 1'b0;
			o_mosi <= w[i];
			repeat (8) @(posedge i_clk_sys);
			if (i < 8) r[i] = i_miso;
			o_sclk <= 1'b1;
			repeat (8) @(posedge i_clk_sys);
			o_sclk <= 1'b0;
		end
		repeat (8) @(posedge i_clk_sys);
		o_cs_n <= 1'b1;
		o_mosi <= ~o_mosi;
		repeat (12) @(posedge i_clk_sys);
	endtask
endmodule

// File: dv/fspc_regs_asserts.sv
// Purpose: port checks of the setup registers
// Assumes: one clock, sync reset
// Notes:   idle_ff counts cycles with cs_n high
module fspc_regs_asserts (
	input wire logic       i_clk_sys,
	input wire logic       i_reset,
	input wire logic       i_cs_n,
	input wire logic       i_bulk_erase,
	input wire logic       o_miso_oe,
	input wire logic       o_pe_whole_array,
	input wire logic [1:0] o_protocol,
	input wire logic       o_hold_reset_en,
	input wire logic       o_vpp_accel_en,
	input wire logic [2:0] o_drive_strength
);
	logic [3:0] idle_ff;
	always_ff @(posedge i_clk_sys) begin
		if (i_reset || !i_cs_n) idle_ff <= 4'h0;
		else if (idle_ff != 4'hF) idle_ff <= idle_ff + 4'h1;
	end
	default clocking @(posedge i_clk_sys); endclocking
	a_bulk_follow: assert property (disable iff (i_reset) i_bulk_erase |=> o_pe_whole_array)
		else $error("whole array flag missing");
	a_bulk_drop: assert property (disable iff (i_reset) !i_bulk_erase |=> !o_pe_whole_array)
		else $error("whole array flag stuck");
	a_oe_quiet: assert property (disable iff (i_reset) idle_ff >= 4'h8 |-> !o_miso_oe)
		else $error("miso driven while idle");
	a_cfg_steady: assert property (disable iff (i_reset) idle_ff >= 4'h8 |->
		$stable(o_protocol) && $stable(o_hold_reset_en) && $stable(o_vpp_accel_en))
		else $error("setup changed while idle");
	a_proto_legal: assert property (disable iff (i_reset) o_protocol != 2'h3)
		else $error("illegal protocol code");
	a_rst_proto: assert property (i_reset |=> o_protocol == 2'h0)
		else $error("protocol not extended after reset");
	a_rst_hold: assert property (i_reset |=> o_hold_reset_en)
		else $error("hold not enabled after reset");
	a_rst_accel: assert property (i_reset |=> !o_vpp_accel_en && o_drive_strength == 3'h7)
		else $error("accel or drive wrong after reset");
	c_quad: cover property (o_protocol == 2'h2);
	c_dual: cover property (o_protocol == 2'h1);
	c_bulk: cover property (o_pe_whole_array);
endmodule
bind fspc_regs fspc_regs_asserts u_chk (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
	.i_cs_n(i_cs_n), .i_bulk_erase(i_bulk_erase), .o_miso_oe(o_miso_oe),
	.o_pe_whole_array(o_pe_whole_array), .o_protocol(o_protocol),
	.o_hold_reset_en(o_hold_reset_en), .o_vpp_accel_en(o_vpp_accel_en),
	.o_drive_strength(o_drive_strength));

// File: dv/testbench.sv
// Purpose: self-checking bench of the setup registers
// Assumes: host model supplies serial frames
// Notes:   rows hold write data, readback, protocol, hold, accel
`include "fspc_cfg.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, rst = 1'b1, cs_n, sclk, mosi, miso, nv = 1'b1, a4 = 1'b0;
	logic bulk = 1'b0, busy = 1'b0, e_er = 1'b0, e_pg = 1'b0, pe, hold, acc;
	logic [1:0] proto;
	logic [2:0] drv;
	logic [24:0] addr;
	logic [7:0] r;
	logic step = 1'b0;
	logic [23:0] haddr = 24'h123456;
	logic [19:0] rows [5] = '{{8'hFF, 8'hDF, 2'h0, 2'h2}, {8'h7F, 8'h5F, 2'h2, 2'h2},
		{8'hBF, 8'h9F, 2'h1, 2'h2}, {8'h3B, 8'h1B, 2'h2, 2'h2}, {8'hE5, 8'hC5, 2'h0, 2'h1}};
	int bad_count = 0, comparisons = 0;
	initial forever #25 clk = ~clk;
	fspc_host host (.i_clk_sys(clk), .i_miso(miso), .o_cs_n(cs_n), .o_sclk(sclk), .o_mosi(mosi));
	fspc_regs dut (.i_clk_sys(clk), .i_reset(rst), .i_cs_n(cs_n), .i_sclk(sclk), .i_mosi(mosi),
		.i_nv_seg_default(nv), .i_addr4_en(a4), .i_host_addr(haddr), .i_bulk_erase(bulk),
		.i_read_step(step), .i_busy(busy), .i_err_erase(e_er), .i_err_prog(e_pg),
		.i_err_vpp(1'b0), .i_err_prot(1'b0), .i_erase_susp(1'b0), .i_prog_susp(1'b0),
		.o_miso(miso), .o_miso_oe(), .o_array_addr(addr), .o_pe_whole_array(pe),
		.o_protocol(proto), .o_hold_reset_en(hold), .o_vpp_accel_en(acc),
		.o_drive_strength(drv));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge clk);
		bad_count++;
		finish_test();
	end
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		host.xfer({`FSPC_CMD_RD_EVS, 8'h00}, 16, r);
		chk(r, 8'hDF);
		host.xfer({`FSPC_CMD_RD_SEG, 8'h00}, 16, r);
		chk(r, 8'h01);
		chk({7'h00, addr[24]}, 8'h01);
		host.xfer({`FSPC_CMD_WR_SEG, 8'h00}, 16, r);
		chk({7'h00, addr[24]}, 8'h00);
		host.xfer({`FSPC_CMD_WR_SEG, 8'hFF}, 16, r);
		host.xfer({`FSPC_CMD_RD_SEG, 8'h00}, 16, r);
		chk(r, 8'h01);
		haddr <= 24'hFFFFFF;
		repeat (3) @(posedge clk);
		chk({7'h00, addr == 25'h1FFFFFF}, 8'h01);
		step <= 1'b1;
		@(posedge clk);
		step <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		chk({7'h00, addr == 25'h0000000}, 8'h01);
		host.xfer({`FSPC_CMD_RD_SEG, 8'h00}, 16, r);
		chk(r, 8'h01);
		foreach (rows[i]) begin
			host.xfer({`FSPC_CMD_WR_EVS, rows[i][19:12]}, 16, r);
			host.xfer({`FSPC_CMD_RD_EVS, 8'h00}, 16, r);
			chk(r, rows[i][11:4]);
			chk({3'h0, proto, hold, acc, 1'b0}, {3'h0, rows[i][3:0], 1'b0});
			chk({5'h00, drv}, {5'h00, rows[i][14:12]});
		end
		bulk <= 1'b1;
		repeat (2) @(posedge clk);
		chk({7'h00, pe}, 8'h01);
		bulk <= 1'b0;
		busy <= 1'b1;
		a4 <= 1'b1;
		host.xfer({`FSPC_CMD_RD_FLAGS, 8'h00}, 16, r);
		chk(r, 8'h01);
		chk({7'h00, addr[24]}, 8'h00);
		busy <= 1'b0;
		a4 <= 1'b0;
		e_er <= 1'b1;
		e_pg <= 1'b1;
		@(posedge clk);
		e_er <= 1'b0;
		e_pg <= 1'b0;
		host.xfer({`FSPC_CMD_RD_FLAGS, 8'h00}, 16, r);
		chk(r, 8'hB0);
		host.xfer({8'h00, `FSPC_CMD_CLR_FLAGS}, 8, r);
		host.xfer({`FSPC_CMD_RD_FLAGS, 8'h00}, 16, r);
		chk(r, 8'h80);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		host.xfer({`FSPC_CMD_RD_EVS, 8'h00}, 16, r);
		chk(r, 8'hDF);
		chk({6'h00, proto}, 8'h00);
		finish_test();
	end
endmodule
